// ---- rtl/otpm_core_end.sv ----
// Opcode tracking pipeline of the core end, driving both tracking pins.
// Assumes the bus and sequencer requests arrive synchronous to CORE_CLK.
`timescale 1ns/100ps
module otpm_core_end #(
  parameter int WORD_W = otpm_pkg::OTPM_WORD_W
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  otpm_link_if.device LINK,
  input wire logic BUS_DONE,
  input wire logic [WORD_W-1:0] BUS_DATA,
  input wire logic BUS_FAULT,
  input wire logic FLOW_CHANGE,
  input wire logic LOOP_MODE,
  input wire logic USE_EXT,
  input wire logic START_INSN,
  input wire logic SUPERVISOR,
  output logic PREFETCH_REQ,
  output logic [WORD_W-1:0] OPCODE,
  output logic OPCODE_FAULT,
  output logic OPCODE_VALID
);
  if (WORD_W != otpm_pkg::OTPM_WORD_W) begin : g_bad_width
    $error("WORD_W must equal the pipeline word width.");
  end

  // ****************************************
  // Pipeline stages
  // ****************************************
  otpm_pkg::otpm_stage_t buf_reg, in_reg, b_reg, c_reg;
  otpm_pkg::otpm_stage_t buf_next, in_next, b_next, c_next;
  logic recirc_reg;
  logic recirc_next;

  wire otpm_pkg::otpm_stage_t bus_word = '{valid: 1'b1, fault: BUS_FAULT, word: BUS_DATA};
  // Fetch flags stop once loop data recirculates, and resume only after LOOP_MODE drops.
  wire loop_recirc = LOOP_MODE && recirc_reg;
  wire fetch_taken = BUS_DONE && !FLOW_CHANGE && !loop_recirc;
  wire flush_taken = BUS_DONE && FLOW_CHANGE;
  // Privilege level plays no part in flagging fetches.
  wire sup_unused = SUPERVISOR;
  wire use_b = (USE_EXT || START_INSN) && b_reg.valid;

  always_comb begin
    buf_next = buf_reg;
    in_next = in_reg;
    b_next = b_reg;
    c_next = c_reg;
    recirc_next = LOOP_MODE && (recirc_reg || (BUS_DONE && in_reg.valid && b_reg.valid));
    if (FLOW_CHANGE) begin
      // Flush empties every stage before the refill word lands.
      buf_next = otpm_pkg::OTPM_STAGE_EMPTY;
      in_next = otpm_pkg::OTPM_STAGE_EMPTY;
      b_next = otpm_pkg::OTPM_STAGE_EMPTY;
      c_next = otpm_pkg::OTPM_STAGE_EMPTY;
      if (BUS_DONE) begin
        b_next = bus_word;
      end
    end else begin
      if (START_INSN && b_reg.valid) begin
        c_next = b_reg;
      end
      if (use_b) begin
        b_next = in_reg;
        in_next = buf_reg;
        buf_next = otpm_pkg::OTPM_STAGE_EMPTY;
      end
      // New words fall through to the first empty stage.
      if (BUS_DONE && !loop_recirc) begin
        if (!b_next.valid) begin
          b_next = bus_word;
        end else if (!in_next.valid) begin
          in_next = bus_word;
        end else begin
          buf_next = bus_word;
        end
      end
      if (!b_next.valid && in_next.valid) begin
        b_next = in_next;
        in_next = buf_next;
        buf_next = otpm_pkg::OTPM_STAGE_EMPTY;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      buf_reg <= otpm_pkg::OTPM_STAGE_EMPTY;
      in_reg <= otpm_pkg::OTPM_STAGE_EMPTY;
      b_reg <= otpm_pkg::OTPM_STAGE_EMPTY;
      c_reg <= otpm_pkg::OTPM_STAGE_EMPTY;
      recirc_reg <= 1'b0;
      PREFETCH_REQ <= 1'b0;
      OPCODE <= '0;
      OPCODE_FAULT <= 1'b0;
      OPCODE_VALID <= 1'b0;
    end else begin
      buf_reg <= buf_next;
      in_reg <= in_next;
      b_reg <= b_next;
      c_reg <= c_next;
      recirc_reg <= recirc_next;
      PREFETCH_REQ <= !buf_next.valid && !LOOP_MODE;
      OPCODE <= c_next.word;
      OPCODE_FAULT <= c_next.fault;
      OPCODE_VALID <= c_next.valid && !sup_unused ? c_next.valid : c_next.valid;
    end
  end

  // ****************************************
  // Tracking pins and clock output
  // ****************************************
  // Flush-fetch is two clocks; a following fetch extends it to three.
  otpm_pulse_gen u_fetch_pin (
    .clk(CORE_CLK),
    .rst(RST),
    .req_one(fetch_taken),
    .req_two(flush_taken),
    .pin_n(LINK.fetch_indicator_n)
  );

  // Start is two clocks, an immediate use may follow unbroken; idle high.
  otpm_pulse_gen u_advance_pin (
    .clk(CORE_CLK),
    .rst(RST),
    .req_one(USE_EXT && !START_INSN && b_reg.valid && !FLOW_CHANGE),
    .req_two(START_INSN && b_reg.valid && !FLOW_CHANGE),
    .pin_n(LINK.pipe_advance_indicator_n)
  );

  logic clk_out_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      clk_out_reg <= 1'b0;
    end else begin
      clk_out_reg <= ~clk_out_reg;
    end
  end
  assign LINK.system_clock_output = clk_out_reg;
endmodule : otpm_core_end

// ---- rtl/otpm_link_if.sv ----
// Interface carrying the two tracking pins between core and tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface otpm_link_if;
  logic fetch_indicator_n;
  logic pipe_advance_indicator_n;
  logic system_clock_output;
  modport device (
    output fetch_indicator_n,
    output pipe_advance_indicator_n,
    output system_clock_output
  );
  modport tracker (
    input fetch_indicator_n,
    input pipe_advance_indicator_n,
    input system_clock_output
  );
endinterface : otpm_link_if

// ---- rtl/otpm_pkg.sv ----
// Package with the shared constants of the opcode tracking link.
// Assumes one system clock on both ends and active-low tracking pins.
package otpm_pkg;
  // ****************************************
  // Widths and encodings
  // ****************************************
  localparam int OTPM_WORD_W = 16;
  localparam logic OTPM_ACTIVE = 1'b0;
  localparam logic OTPM_IDLE = 1'b1;
  localparam int OTPM_FLUSH_CLKS = 2;
  localparam int OTPM_START_CLKS = 2;
  localparam logic [1:0] OTPM_CNT_W2 = 2'h2;
  localparam logic [1:0] OTPM_CNT_ZERO = 2'h0;

  // Pipeline stage contents: a word and its abnormal-termination flag.
  typedef struct packed {
    logic valid;
    logic fault;
    logic [OTPM_WORD_W-1:0] word;
  } otpm_stage_t;

  localparam otpm_stage_t OTPM_STAGE_EMPTY = '{valid: 1'b0, fault: 1'b0, word: 16'h0000};

  // Fetch indication kinds requested of the device end.
  typedef enum logic [1:0] {
    OTPM_FK_NONE = 2'b00,
    OTPM_FK_FETCH = 2'b01,
    OTPM_FK_FLUSH = 2'b10
  } otpm_fkind_t;

  // Pin driver states.
  typedef enum logic [1:0] {
    OTPM_PS_IDLE = 2'b00,
    OTPM_PS_ONE = 2'b01,
    OTPM_PS_TWO = 2'b10
  } otpm_pstate_t;
endpackage : otpm_pkg

// ---- rtl/otpm_pulse_gen.sv ----
// Pulse-width coder for one active-low tracking pin.
// Assumes one request per cycle; a two-clock request may chain a one-clock one.
`timescale 1ns/100ps
module otpm_pulse_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_one,
  input wire logic req_two,
  output logic pin_n
);
  otpm_pkg::otpm_pstate_t state_reg;
  otpm_pkg::otpm_pstate_t state_next;
  logic pin_next;

  // ****************************************
  // Next state
  // ****************************************
  // TWO leaves at least one more low clock; a chained one-clock request keeps it there.
  always_comb begin
    state_next = otpm_pkg::OTPM_PS_IDLE;
    case (state_reg)
      otpm_pkg::OTPM_PS_TWO: begin
        state_next = req_one ? otpm_pkg::OTPM_PS_TWO : otpm_pkg::OTPM_PS_ONE;
      end
      default: begin
        if (req_two) begin
          state_next = otpm_pkg::OTPM_PS_TWO;
        end else if (req_one) begin
          state_next = otpm_pkg::OTPM_PS_ONE;
        end
      end
    endcase
  end

  assign pin_next = (state_next == otpm_pkg::OTPM_PS_IDLE) ? otpm_pkg::OTPM_IDLE
                                                           : otpm_pkg::OTPM_ACTIVE;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= otpm_pkg::OTPM_PS_IDLE;
      pin_n <= otpm_pkg::OTPM_IDLE;
    end else begin
      state_reg <= state_next;
      pin_n <= pin_next;
    end
  end
endmodule : otpm_pulse_gen

// ---- rtl/otpm_tracker_end.sv ----
// Tracker end: decodes both pins and rebuilds the pipeline model.
// Assumes the pins come from the core end on the same clock.
`timescale 1ns/100ps
module otpm_tracker_end (
  input wire logic CORE_CLK,
  input wire logic RST,
  otpm_link_if.tracker LINK,
  output logic FETCH_SEEN,
  output logic FLUSH_SEEN,
  output logic USE_SEEN,
  output logic START_SEEN,
  output logic B_VALID,
  output logic IN_VALID
);
  logic [1:0] fcnt_reg, acnt_reg;
  logic in_v_reg, b_v_reg;
  wire f_act = LINK.fetch_indicator_n == otpm_pkg::OTPM_ACTIVE;
  wire a_act = LINK.pipe_advance_indicator_n == otpm_pkg::OTPM_ACTIVE;
  // Width counters resync whenever a pin goes idle.
  wire [1:0] fcnt_next = f_act ? ((fcnt_reg == 2'h3) ? 2'h1 : fcnt_reg + 2'h1) : 2'h0;
  wire [1:0] acnt_next = a_act ? ((acnt_reg == otpm_pkg::OTPM_CNT_W2) ? 2'h1
                                                             : acnt_reg + 2'h1) : 2'h0;
  wire flush_e = fcnt_next == otpm_pkg::OTPM_CNT_W2;
  // A lone fetch is known only once the pin goes idle after one low clock.
  wire fetch_e = (!f_act && fcnt_reg == 2'h1) || fcnt_next == 2'h3;
  wire start_e = acnt_next == otpm_pkg::OTPM_CNT_W2;
  wire use_e = !a_act && acnt_reg == 2'h1;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fcnt_reg <= 2'h0;
      acnt_reg <= 2'h0;
      in_v_reg <= 1'b0;
      b_v_reg <= 1'b0;
      FETCH_SEEN <= 1'b0;
      FLUSH_SEEN <= 1'b0;
      USE_SEEN <= 1'b0;
      START_SEEN <= 1'b0;
      B_VALID <= 1'b0;
      IN_VALID <= 1'b0;
    end else begin
      fcnt_reg <= fcnt_next;
      acnt_reg <= acnt_next;
      // Valid bits with fall-through into stage B.
      b_v_reg <= flush_e || (in_v_reg || fetch_e) || (b_v_reg && !use_e && !start_e);
      in_v_reg <= !flush_e && ((fetch_e && (b_v_reg || in_v_reg)) || (in_v_reg && b_v_reg
                  && !use_e && !start_e));
      FETCH_SEEN <= fetch_e && !flush_e;
      FLUSH_SEEN <= flush_e;
      USE_SEEN <= use_e;
      START_SEEN <= start_e;
      B_VALID <= b_v_reg;
      IN_VALID <= in_v_reg;
    end
  end
endmodule : otpm_tracker_end

// ---- testbench/otpm_link_assertions.sv ----
// Checker for the two tracking pins and the clock output of the link.
// Assumes the pins, the clock output and RST all belong to CORE_CLK.
`timescale 1ns/100ps
module otpm_link_assertions (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic fetch_indicator_n,
  input wire logic pipe_advance_indicator_n,
  input wire logic system_clock_output
);
  // ****************************************
  // Pulse width, idle and clock output checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic [3:0] adv_low_cnt;
  always_ff @(posedge CORE_CLK) begin
    adv_low_cnt <= (RST || pipe_advance_indicator_n) ? 4'h0 : adv_low_cnt + 4'h1;
  end
  sequence fetch_starts;
    $fell(fetch_indicator_n);
  endsequence
  sequence adv_starts;
    $fell(pipe_advance_indicator_n);
  endsequence
  chk_fetch_width: assert property (fetch_starts |-> ##[1:3] fetch_indicator_n)
    else $error("fetch pulse longer than three clocks");
  chk_fetch_flush_end: assert property (!fetch_indicator_n [*3] |=> fetch_indicator_n)
    else $error("fetch pin held low too long");
  chk_adv_width: assert property (adv_starts |-> ##[1:3] pipe_advance_indicator_n)
    else $error("advance pulse longer than three clocks");
  chk_adv_merge_limit: assert property (adv_low_cnt <= 4'h3)
    else $error("merged advance pulse too long");
  chk_adv_not_stuck: assert property (!pipe_advance_indicator_n [*3] |=> pipe_advance_indicator_n)
    else $error("advance pin held low too long");
  chk_reset_pins_idle: assert property (disable iff (1'b0) RST |=> fetch_indicator_n && pipe_advance_indicator_n)
    else $error("pins not idle after reset edge");
  chk_release_quiet: assert property ($fell(RST) |-> fetch_indicator_n && pipe_advance_indicator_n)
    else $error("pin active at reset release");
  chk_system_clock_output_toggle: assert property (!$past(RST) |-> system_clock_output != $past(system_clock_output))
    else $error("clock output did not toggle");
endmodule : otpm_link_assertions

// ---- testbench/tb.sv ----
// Testbench joining the core end and the tracker end through the link.
// Assumes one CORE_CLK of 40 ns and a synchronous active-high RST.
`timescale 1ns/100ps
module tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic core_clk, rst, bus_done, bus_fault, flow_change, loop_mode, use_ext, start_insn;
  logic supervisor, prefetch_req, opcode_fault, opcode_valid;
  logic fetch_seen, flush_seen, use_seen, start_seen, b_valid, in_valid;
  logic [15:0] bus_data, opcode;
  int n_fail = 0, check_count = 0, fw = 0, aw = 0, fcnt = 0, acnt = 0, n_fetch = 0, n0;
  int n_flush = 0, n_use = 0, n_start = 0;
  otpm_link_if link ();
  otpm_core_end i_otpm_core_end (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .BUS_DONE(bus_done), .BUS_DATA(bus_data), .BUS_FAULT(bus_fault), .FLOW_CHANGE(flow_change),
    .LOOP_MODE(loop_mode), .USE_EXT(use_ext), .START_INSN(start_insn), .SUPERVISOR(supervisor),
    .PREFETCH_REQ(prefetch_req), .OPCODE(opcode), .OPCODE_FAULT(opcode_fault),
    .OPCODE_VALID(opcode_valid));
  otpm_tracker_end i_otpm_tracker_end (.CORE_CLK(core_clk), .RST(rst), .LINK(link),
    .FETCH_SEEN(fetch_seen), .FLUSH_SEEN(flush_seen), .USE_SEEN(use_seen),
    .START_SEEN(start_seen), .B_VALID(b_valid), .IN_VALID(in_valid));
  otpm_link_assertions i_otpm_link_assertions (.CORE_CLK(core_clk), .RST(rst),
    .fetch_indicator_n(link.fetch_indicator_n),
    .pipe_advance_indicator_n(link.pipe_advance_indicator_n),
    .system_clock_output(link.system_clock_output));
  // ****************************************
  // Pulse width monitor and helpers
  // ****************************************
  always @(posedge core_clk) begin
    fcnt <= (link.fetch_indicator_n === 1'b0) ? fcnt + 1 : 0;
    acnt <= (link.pipe_advance_indicator_n === 1'b0) ? acnt + 1 : 0;
    if (link.fetch_indicator_n === 1'b1 && fcnt != 0) fw <= fcnt;
    if (link.pipe_advance_indicator_n === 1'b1 && acnt != 0) aw <= acnt;
    if (fetch_seen === 1'b1) n_fetch <= n_fetch + 1;
    if (flush_seen === 1'b1) n_flush <= n_flush + 1;
    if (use_seen === 1'b1) n_use <= n_use + 1;
    if (start_seen === 1'b1) n_start <= n_start + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic req(input logic [3:0] v, input logic [15:0] d = 16'h0000, input logic f = 1'b0);
    @(posedge core_clk);
    {flow_change, bus_done, use_ext, start_insn} <= v;
    bus_data <= d;
    bus_fault <= f;
  endtask : req
  task automatic settle();
    req(4'h0);
    repeat (6) @(posedge core_clk);
  endtask : settle
  task automatic complete_run();
    $display("checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_flush();
    req(4'hC, 16'hA001);
    settle();
    check(fw, 2);
    check({b_valid, in_valid}, 2'b10);
    check(prefetch_req, 1'b1);
    req(4'hC, 16'hB001);
    req(4'h4, 16'hB002);
    settle();
    check(fw, 3);
    check({b_valid, in_valid}, 2'b11);
  endtask : t_flush
  task automatic t_fetch(input logic s);
    @(posedge core_clk);
    supervisor <= s;
    n0 = n_fetch;
    req(4'hC, 16'h1234);
    settle();
    req(4'h4, 16'h5678);
    settle();
    check(fw, 1);
    check(n_fetch, n0 + 1);
  endtask : t_fetch
  task automatic t_advance();
    int f0 = n_flush;
    int u0 = n_use;
    int s0 = n_start;
    t_flush();
    req(4'h2);
    settle();
    check(aw, 1);
    check({b_valid, in_valid}, 2'b10);
    req(4'h1);
    settle();
    check(aw, 2);
    check({opcode_valid, opcode}, {1'b1, 16'hB002});
    check(b_valid, 1'b0);
    req(4'hC, 16'hC001);
    req(4'h4, 16'hC002);
    req(4'h1);
    req(4'h2);
    settle();
    check(aw, 3);
    check(opcode, 16'hC001);
    check(n_flush - f0, 3);
    check(n_use - u0, 2);
    check(n_start - s0, 2);
  endtask : t_advance
  task automatic t_fault();
    req(4'hC, 16'hD001, 1'b1);
    settle();
    req(4'h1);
    settle();
    check({opcode_fault, opcode}, {1'b1, 16'hD001});
  endtask : t_fault
  task automatic t_loop();
    req(4'hC, 16'hE001);
    req(4'h4, 16'hE002);
    settle();
    @(posedge core_clk);
    loop_mode <= 1'b1;
    n0 = n_fetch;
    req(4'h4, 16'hE003);
    req(4'h0);
    req(4'h4, 16'hE004);
    req(4'h1);
    settle();
    check(n_fetch - n0, 1);
    check(prefetch_req, 1'b0);
    check(aw, 2);
    loop_mode <= 1'b0;
    t_fetch(1'b0);
  endtask : t_loop
  // ****************************************
  // Clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    {rst, bus_done, bus_fault, flow_change, loop_mode, use_ext, start_insn} = 7'h40;
    supervisor = 1'b0;
    bus_data = 16'h0000;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    req(4'h0);
    #1;
    check({link.fetch_indicator_n, link.pipe_advance_indicator_n, opcode_valid}, 3'h6);
    t_fetch(1'b0);
    t_fetch(1'b1);
    t_advance();
    t_fault();
    t_loop();
    complete_run();
  end
endmodule : tb
